// ---- servo_mode_and_option_control_bench.sv ----
/*
  self-checking bench for the mode and option control block over apb.
  assumes the partner model drives the mode pins; runtime tick shortened.
*/
`timescale 1ns/10ps
module servo_mode_and_option_control_bench;
  import smc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        pin_a, pin_b, flt, uv, ro, ac, dp, hn, ff, tfe, pf, vf, fs, am, rf, hs;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, rt;
  logic [15:0] volt, temp;
  logic [2:0]  msel;
  logic [1:0]  want, em;
  smc_mode_t   active_mode;
  int          fail_count, compares;
  smc_mode_ctrl #(.MS_CYCLES(10)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .mode_select_input_a(pin_a), .mode_select_input_b(pin_b), .bus_voltage_in(volt),
    .motor_temp_in(temp), .resolver_fault_in(flt), .resolver_fault_clear_in(1'b0),
    .active_mode(active_mode), .analog_input_autocorr_en(ac), .do_protection_disable(dp),
    .homing_no_offset(hn), .relay_open(ro), .undervoltage(uv), .ff_from_velocity(ff),
    .torque_ff_enable(tfe), .phase_find_start(pf), .tuning_vf_only(vf),
    .resolver_freq_select(fs), .resolver_amplitude_check(am), .resolver_fault(rf),
    .pulse_from_high_speed(hs));
  smc_mode_driver ctl_u (.pclk(pclk), .sel(msel), .want(want), .pin_a(pin_a), .pin_b(pin_b));
  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  always #10 pclk = ~pclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic results;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge pclk);
    fail_count++;
    results();
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, flt, paddr, pwdata, msel, want} = '0;
    fail_count = 0;
    compares = 0;
    volt = 16'h00C8;
    temp = 16'h0123;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    wt(1);
    apb(0, OFF_OPTION_A, 0);
    chk(rd, 32'h0000_00DC);
    apb(0, OFF_OPTION_B, 0);
    chk(rd, 32'h0000_0002);
    apb(0, OFF_MODE_SEL, 0);
    chk(rd, 0);
    apb(1, OFF_ID_PRIMARY, 32'h0000_FFFF);
    apb(0, OFF_ID_PRIMARY, 0);
    chk(rd, {16'h0, ID_PRIMARY_VAL});
    apb(0, OFF_MOTOR_TEMP, 0);
    chk(rd, 32'h0000_0123);
    apb(0, 8'h3C, 0);
    chk(32'(err), 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    apb(0, OFF_RUNTIME, 0);
    rt = rd;
    apb(1, OFF_RUNTIME, 32'h0000_0000);
    wt(14);
    apb(0, OFF_RUNTIME, 0);
    chk(rd - rt, 32'h0000_0002);
    for (int s = 0; s < 8; s++) begin
      apb(1, OFF_MODE_SEL, s);
      apb(0, OFF_MODE_SEL, 0);
      chk(rd, s);
      for (int w = 0; w < 3; w++) begin
        msel <= 3'(s);
        want <= 2'(w);
        case (s)
          0, 1, 2: em = 2'(s);
          3: em = (w == 2) ? SMC_TORQUE : SMC_POSITION;
          4: em = (w == 1) ? SMC_SPEED : SMC_POSITION;
          5: em = (w == 2) ? SMC_TORQUE : SMC_SPEED;
          6: em = 2'(w);
          default: em = SMC_DEDICATED;
        endcase
        wt(6);
        chk(32'(active_mode), 32'(em));
      end
    end
    apb(1, OFF_OPTION_A, 32'h0000_0A03);
    wt(2);
    chk({ac, dp, hn}, 3'b111);
    foreach (em[i]) begin
      volt <= i ? 16'h00A3 : 16'h00A4;
      wt(8);
      chk({uv, ro}, i ? 2'b11 : 2'b00);
    end
    apb(0, OFF_BUS_VOLT, 0);
    chk(rd, 32'h0000_00A4);
    apb(1, OFF_OPTION_A, 32'h0000_0000);
    volt <= 16'h0064;
    wt(8);
    chk({ac, dp, hn, uv, ro}, 5'b00010);
    foreach (em[i]) begin
      apb(1, OFF_OPTION_B, i ? 32'h0000_00BF : 32'h0000_0000);
      chk(pf, i);
      wt(2);
      chk({ff, tfe, vf, fs, am, hs}, i ? 6'b101111 : 6'b010000);
    end
    apb(1, OFF_OPTION_B, 0);
    apb(1, OFF_FF_MODE, 2);
    wt(2);
    chk(tfe, 1'b0);
    flt <= 1'b1;
    wt(5);
    flt <= 1'b0;
    wt(5);
    chk(rf, 1'b1);
    apb(1, OFF_OPTION_B, 32'h0000_0040);
    wt(3);
    chk(rf, 1'b0);
    chk(pf, 1'b0);
    presetn <= 1'b0;
    wt(2);
    presetn <= 1'b1;
    wt(1);
    apb(0, OFF_OPTION_B, 0);
    chk(rd, 32'h0000_0002);
    apb(1, OFF_OPTION_B, 32'h0000_0004);
    chk(pf, 1'b1);
    apb(1, OFF_OPTION_B, 32'h0000_0004);
    chk(pf, 1'b0);
    results();
  end
endmodule : servo_mode_and_option_control_bench

// ---- smc_mode_ctrl.sv ----
/*
  servo mode selection and option word control with an apb register file.
  assumes mode select pins, samples and resolver fault lines come from outside
  pclk domain; motor loops consume the decoded outputs.
*/
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
module smc_mode_ctrl
  import smc_pkg::*;
#(
  parameter int          CLK_HZ       = 50000000,
  parameter int          MS_CYCLES    = CLK_HZ / 1000,
  parameter logic [15:0] ID_PRIMARY   = ID_PRIMARY_VAL,
  parameter logic [15:0] ID_SECONDARY = ID_SECONDARY_VAL
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        mode_select_input_a,
  input  wire logic        mode_select_input_b,
  input  wire logic [15:0] bus_voltage_in,
  input  wire logic [15:0] motor_temp_in,
  input  wire logic        resolver_fault_in,
  input  wire logic        resolver_fault_clear_in,
  output smc_pkg::smc_mode_t active_mode,
  output logic             analog_input_autocorr_en,
  output logic             do_protection_disable,
  output logic             homing_no_offset,
  output logic             relay_open,
  output logic             undervoltage,
  output logic             ff_from_velocity,
  output logic             torque_ff_enable,
  output logic             phase_find_start,
  output logic             tuning_vf_only,
  output logic             resolver_freq_select,
  output logic             resolver_amplitude_check,
  output logic             resolver_fault,
  output logic             pulse_from_high_speed
);

  import smc_pkg::*;

  // ------------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------------
  logic [3:0]  pins_sync;
  logic        sel_a;
  logic        sel_b;
  logic        res_fault_s;
  logic        res_clr_s;
  logic [15:0] volt_s1;
  logic [15:0] volt_s2;
  logic [15:0] temp_s1;
  logic [15:0] temp_s2;

  smc_sync #(.WIDTH(4)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({resolver_fault_clear_in, resolver_fault_in,
                mode_select_input_b, mode_select_input_a}),
    .sync_out (pins_sync)
  );

  assign sel_a       = pins_sync[0];
  assign sel_b       = pins_sync[1];
  assign res_fault_s = pins_sync[2];
  assign res_clr_s   = pins_sync[3];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      volt_s1 <= 16'h0000;
      volt_s2 <= 16'h0000;
      temp_s1 <= 16'h0000;
      temp_s2 <= 16'h0000;
    end else begin
      volt_s1 <= bus_voltage_in;
      volt_s2 <= volt_s1;
      temp_s1 <= motor_temp_in;
      temp_s2 <= temp_s1;
    end
  end

  // ------------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------------
  logic [15:0] option_word_a;
  logic [15:0] option_word_b;
  logic [2:0]  control_mode_selector;
  logic [15:0] rated_voltage;
  logic [1:0]  feedforward_mode_param;
  logic [31:0] runtime_ms;
  logic [31:0] ms_count;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic [31:0] next_prdata;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  always_comb begin
    addr_ok     = 1'b1;
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      OFF_BUS_VOLT:     next_prdata = {16'h0000, volt_s2};
      OFF_MOTOR_TEMP:   next_prdata = {16'h0000, temp_s2};
      OFF_RUNTIME:      next_prdata = runtime_ms;
      OFF_ID_PRIMARY:   next_prdata = {16'h0000, ID_PRIMARY};
      OFF_ID_SECONDARY: next_prdata = {16'h0000, ID_SECONDARY};
      OFF_OPTION_A:     next_prdata = {16'h0000, option_word_a};
      OFF_OPTION_B:     next_prdata = {16'h0000, option_word_b};
      OFF_MODE_SEL:     next_prdata = {29'h0, control_mode_selector};
      OFF_MODE_STATUS:  next_prdata = {30'h0, active_mode};
      OFF_RATED_VOLT:   next_prdata = {16'h0000, rated_voltage};
      OFF_FF_MODE:      next_prdata = {30'h0, feedforward_mode_param};
      default:          addr_ok     = 1'b0;
    endcase
  end

  // zero wait state: pready registered high for the one access cycle after each setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (psel && !penable && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  // ------------------------------------------------------------------
  // writable registers
  // ------------------------------------------------------------------
  logic wr_take;
  assign wr_take = wr_en && pready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      option_word_a          <= RST_OPTION_A;
      option_word_b          <= RST_OPTION_B;
      control_mode_selector  <= RST_MODE_SEL;
      rated_voltage          <= RST_RATED_VOLT;
      feedforward_mode_param <= RST_FF_MODE;
    end else if (wr_take) begin
      unique case (paddr)
        OFF_OPTION_A:   option_word_a          <= pwdata[15:0];
        OFF_OPTION_B:   option_word_b          <= pwdata[15:0];
        OFF_MODE_SEL:   control_mode_selector  <= pwdata[2:0];
        OFF_RATED_VOLT: rated_voltage          <= pwdata[15:0];
        OFF_FF_MODE:    feedforward_mode_param <= pwdata[1:0];
        default:        ;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // run time counter in milliseconds
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_count   <= 32'h0000_0000;
      runtime_ms <= 32'h0000_0000;
    end else if (ms_count == 32'(MS_CYCLES - 1)) begin
      ms_count   <= 32'h0000_0000;
      runtime_ms <= runtime_ms + 32'h0000_0001;
    end else begin
      ms_count <= ms_count + 32'h0000_0001;
    end
  end

  // ------------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------------
  smc_mode_t next_mode;

  always_comb begin
    next_mode = SMC_POSITION;
    unique case (control_mode_selector)
      SEL_POSITION:  next_mode = SMC_POSITION;
      SEL_SPEED:     next_mode = SMC_SPEED;
      SEL_TORQUE:    next_mode = SMC_TORQUE;
      SEL_POS_TRQ:   next_mode = sel_a ? SMC_TORQUE : SMC_POSITION;
      SEL_POS_SPD:   next_mode = sel_a ? SMC_SPEED : SMC_POSITION;
      SEL_SPD_TRQ:   next_mode = sel_a ? SMC_TORQUE : SMC_SPEED;
      SEL_THREE_WAY: next_mode = sel_b ? SMC_POSITION : (sel_a ? SMC_TORQUE : SMC_SPEED);
      SEL_DEDICATED: next_mode = SMC_DEDICATED;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_mode <= SMC_POSITION;
    end else begin
      active_mode <= next_mode;
    end
  end

  // ------------------------------------------------------------------
  // undervoltage and relay
  // ------------------------------------------------------------------
  logic [33:0] uv_thresh;
  logic        below_uv;

  assign uv_thresh = 34'(rated_voltage) * 34'(UV_FRAC_Q16);
  assign below_uv  = ({2'b00, volt_s2, 16'h0000} < uv_thresh);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      undervoltage <= 1'b0;
      relay_open   <= 1'b0;
    end else begin
      undervoltage <= below_uv;
      if (option_word_a[OPA_UV_RELAY] && below_uv) begin
        relay_open <= 1'b1;
      end else if (!below_uv) begin
        relay_open <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // option outputs
  // ------------------------------------------------------------------
  logic power_on_seen;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_input_autocorr_en <= 1'b0;
      do_protection_disable    <= 1'b0;
      homing_no_offset         <= 1'b0;
      ff_from_velocity         <= 1'b0;
      torque_ff_enable         <= 1'b0;
      tuning_vf_only           <= 1'b0;
      resolver_freq_select     <= 1'b0;
      resolver_amplitude_check <= 1'b0;
      pulse_from_high_speed    <= 1'b0;
    end else begin
      analog_input_autocorr_en <= option_word_a[OPA_AI_CORR];
      do_protection_disable    <= option_word_a[OPA_DO_PROT_OFF];
      homing_no_offset         <= option_word_a[OPA_HOME_NO_OFFS];
      ff_from_velocity         <= option_word_b[OPB_FF_LEGACY];
      torque_ff_enable         <= (feedforward_mode_param <= 2'h1) && !option_word_b[OPB_FF_DISABLE];
      tuning_vf_only           <= option_word_b[OPB_TUNE_VF_ONLY];
      resolver_freq_select     <= option_word_b[OPB_RES_FREQ];
      resolver_amplitude_check <= option_word_b[OPB_RES_AMCHK];
      pulse_from_high_speed    <= option_word_b[OPB_PULSE_HS];
    end
  end

  // one pulse on the start-up load of option word b after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_on_seen    <= 1'b0;
      phase_find_start <= 1'b0;
    end else begin
      if (wr_take && (paddr == OFF_OPTION_B)) begin
        power_on_seen <= 1'b1;
      end
      phase_find_start <= !power_on_seen && wr_take && (paddr == OFF_OPTION_B)
                          && pwdata[OPB_PHASE_FIND];
    end
  end

  // sticky fault, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resolver_fault <= 1'b0;
    end else if (res_fault_s) begin
      resolver_fault <= 1'b1;
    end else if (option_word_b[OPB_RES_AUTOCLR] || res_clr_s) begin
      resolver_fault <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  a_mode_three_way: assert property (@(posedge pclk) disable iff (!presetn)
    control_mode_selector == SEL_THREE_WAY && sel_b |=> active_mode == SMC_POSITION)
    else $error("selector 6 with input b did not give position");
  a_mode_pos_spd: assert property (@(posedge pclk) disable iff (!presetn)
    control_mode_selector == SEL_POS_SPD |=> active_mode == ($past(sel_a) ? SMC_SPEED : SMC_POSITION))
    else $error("selector 4 mode wrong");
  a_mode_fixed: assert property (@(posedge pclk) disable iff (!presetn)
    control_mode_selector == SEL_TORQUE [*2] |-> active_mode == SMC_TORQUE)
    else $error("selector 2 did not give torque");
  a_relay_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !option_word_a[OPA_UV_RELAY] && !relay_open |=> !relay_open)
    else $error("relay opened with release disabled");
  a_ff_gate: assert property (@(posedge pclk) disable iff (!presetn)
    option_word_b[OPB_FF_DISABLE] |=> !torque_ff_enable)
    else $error("feedforward enabled while disabled");
  a_pulse_src: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(option_word_b[OPB_PULSE_HS]) |=> pulse_from_high_speed == $past(option_word_b[OPB_PULSE_HS]))
    else $error("pulse source lagged");
  a_ro_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_take && paddr == OFF_RUNTIME |=> $stable(option_word_a) && $stable(option_word_b))
    else $error("read only write disturbed options");
  a_res_autoclr: assert property (@(posedge pclk) disable iff (!presetn)
    option_word_b[OPB_RES_AUTOCLR] && !res_fault_s |=> !resolver_fault)
    else $error("resolver fault not cleared");
  a_ai_corr: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 analog_input_autocorr_en == $past(option_word_a[OPA_AI_CORR]))
    else $error("auto correction enable wrong");
  a_phase_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    phase_find_start |=> !phase_find_start)
    else $error("phase finding start longer than one cycle");
  c_three_way: cover property (@(posedge pclk) disable iff (!presetn)
    control_mode_selector == SEL_THREE_WAY ##1 active_mode == SMC_TORQUE);
  c_relay_open: cover property (@(posedge pclk) disable iff (!presetn) $rose(relay_open));
  c_option_write: cover property (@(posedge pclk) disable iff (!presetn)
    wr_take && paddr == OFF_OPTION_B);

endmodule : smc_mode_ctrl

// ---- smc_mode_driver.sv ----
/*
  partner model: the external controller that drives the two mode select pins.
  assumes the bench hands it the selector in use and the wanted mode.
*/
`timescale 1ns/10ps
module smc_mode_driver (
  input  wire logic       pclk,
  input  wire logic [2:0] sel,
  input  wire logic [1:0] want,
  output logic            pin_a,
  output logic            pin_b
);
  import smc_pkg::*;
  // ------------------------------------------------------------------
  // pin levels; a pin that carries no meaning toggles every cycle
  // ------------------------------------------------------------------
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end
  always @(posedge pclk) begin
    case (sel)
      SEL_POS_TRQ, SEL_SPD_TRQ: begin
        pin_a <= (want == SMC_TORQUE);
        pin_b <= ~pin_b;
      end
      SEL_POS_SPD: begin
        pin_a <= (want == SMC_SPEED);
        pin_b <= ~pin_b;
      end
      SEL_THREE_WAY: begin
        pin_a <= (want == SMC_TORQUE) || ((want == SMC_POSITION) && !pin_a);
        pin_b <= (want == SMC_POSITION);
      end
      default: begin
        pin_a <= ~pin_a;
        pin_b <= ~pin_b;
      end
    endcase
  end
endmodule : smc_mode_driver

// ---- smc_pkg.sv ----
/*
  package for the servo mode and option control block: register offsets,
  field positions, reset values and mode encodings.
  assumes an apb slave with 32-bit data, one aligned word per register.
*/
package smc_pkg;

  // ------------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] OFF_BUS_VOLT      = 8'h00;
  localparam logic [7:0] OFF_MOTOR_TEMP    = 8'h04;
  localparam logic [7:0] OFF_RUNTIME       = 8'h08;
  localparam logic [7:0] OFF_ID_PRIMARY    = 8'h0C;
  localparam logic [7:0] OFF_ID_SECONDARY  = 8'h10;
  localparam logic [7:0] OFF_OPTION_A      = 8'h14;
  localparam logic [7:0] OFF_OPTION_B      = 8'h18;
  localparam logic [7:0] OFF_MODE_SEL      = 8'h1C;
  localparam logic [7:0] OFF_MODE_STATUS   = 8'h20;
  localparam logic [7:0] OFF_RATED_VOLT    = 8'h24;
  localparam logic [7:0] OFF_FF_MODE       = 8'h28;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [15:0] RST_OPTION_A     = 16'h00DC;
  localparam logic [15:0] RST_OPTION_B     = 16'h0002;
  localparam logic [2:0]  RST_MODE_SEL     = 3'h0;
  localparam logic [15:0] RST_RATED_VOLT   = 16'h00DC;
  localparam logic [1:0]  RST_FF_MODE      = 2'h0;
  localparam logic [15:0] ID_PRIMARY_VAL   = 16'h1234; // arbitrary value
  localparam logic [15:0] ID_SECONDARY_VAL = 16'h5678; // arbitrary value

  // ------------------------------------------------------------------
  // option word a fields
  // ------------------------------------------------------------------
  localparam int OPA_AI_CORR      = 0;
  localparam int OPA_DO_PROT_OFF  = 1;
  localparam int OPA_HOME_NO_OFFS = 9;
  localparam int OPA_UV_RELAY     = 11;

  // ------------------------------------------------------------------
  // option word b fields
  // ------------------------------------------------------------------
  localparam int OPB_FF_LEGACY    = 0;
  localparam int OPB_FF_DISABLE   = 1;
  localparam int OPB_PHASE_FIND   = 2;
  localparam int OPB_TUNE_VF_ONLY = 3;
  localparam int OPB_RES_FREQ     = 4;
  localparam int OPB_RES_AMCHK    = 5;
  localparam int OPB_RES_AUTOCLR  = 6;
  localparam int OPB_PULSE_HS     = 7;

  // ------------------------------------------------------------------
  // undervoltage threshold factors 0.65 * 1.1414, in 1/65536 units
  // ------------------------------------------------------------------
  localparam logic [17:0] UV_FACTOR_NUM = 18'd65;
  localparam logic [17:0] UV_FACTOR_MUL = 18'd11414;
  localparam int          UV_FACTOR_DEN = 1000000;
  localparam logic [17:0] UV_FRAC_Q16   =
    18'((longint'(65536) * UV_FACTOR_NUM * UV_FACTOR_MUL + UV_FACTOR_DEN - 1) / UV_FACTOR_DEN);

  // ------------------------------------------------------------------
  // modes
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    SMC_POSITION  = 2'h0,
    SMC_SPEED     = 2'h1,
    SMC_TORQUE    = 2'h2,
    SMC_DEDICATED = 2'h3
  } smc_mode_t;

  localparam logic [2:0] SEL_POSITION   = 3'h0;
  localparam logic [2:0] SEL_SPEED      = 3'h1;
  localparam logic [2:0] SEL_TORQUE     = 3'h2;
  localparam logic [2:0] SEL_POS_TRQ    = 3'h3;
  localparam logic [2:0] SEL_POS_SPD    = 3'h4;
  localparam logic [2:0] SEL_SPD_TRQ    = 3'h5;
  localparam logic [2:0] SEL_THREE_WAY  = 3'h6;
  localparam logic [2:0] SEL_DEDICATED  = 3'h7;

endpackage : smc_pkg

// ---- smc_sync.sv ----
/*
  two flip-flop synchroniser, one per bit.
  assumes inputs asynchronous to pclk.
*/
`timescale 1ns/10ps
module smc_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // ------------------------------------------------------------------
  // two stages per bit
  // ------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stage1[i]   <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          stage1[i]   <= async_in[i];
          sync_out[i] <= stage1[i];
        end
      end
    end
  endgenerate

endmodule : smc_sync
